// ### rtl/aicq_core.sv
// Command queue fetch, opcode decode, parallel I/O port and registers
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Port bits 3..1 drive codec select, powerdown, reset
// - Line drives only while upper-nibble enable set
// - Enabled line with data set drives high
// - Test register has no functional effect
// - Queue pointer holds current command address
// - Pointer write sets run bit, starts command
// - No fetch activity until pointer written
// - Pointer read returns command in execution
// - Interrupt pointer loaded only by init command
// - Command word one, optional pointer word for jump or init
// - Opcode taken from bits 31 to 28
// - Bit 27 raises completion event with opcode, except on reserved opcode 0xF
// - Decode wait, pause, jump, init, report
// - 0x5 sets pipe, 0x8 short pipe
// - 0x7 defines slot start and length
// - 0x6 sets pipe, same as 0x5
// - Pause suspends execution until resumed
// - 0xB TE modes, 0xA NT modes
// - 0x9 highway global, 0xE highway data mode
// - Reset clears pipes, slots, parallel I/O
module aicq_core
	import aicq_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic [3:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	output logic o_mem_req,
	output logic [31:0] o_mem_addr,
	input wire logic i_mem_ack,
	input wire logic [31:0] i_mem_rdata,
	input wire logic i_resume,
	input wire logic [3:0] i_pio_in,
	output logic [3:0] o_pio_out,
	output logic [3:0] o_pio_oe,
	output logic o_cmd_done,
	output logic [3:0] o_cmd_done_op
);
	// ****************************************
	// Input synchronisers and soft reset
	// ****************************************
	logic [3:0] pio_s1_q, pio_s2_q;
	logic res_s1_q, res_s2_q, res_s3_q;
	logic [1:0] swrst_cnt_q;
	logic swrst;
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			pio_s1_q <= 4'h0;
			pio_s2_q <= 4'h0;
			res_s1_q <= 1'b0;
			res_s2_q <= 1'b0;
			res_s3_q <= 1'b0;
		end
		else
		begin
			pio_s1_q <= i_pio_in;
			pio_s2_q <= pio_s1_q;
			res_s1_q <= i_resume;
			res_s2_q <= res_s1_q;
			res_s3_q <= res_s2_q;
		end
	end
	wire resume_rise = res_s2_q & ~res_s3_q;
	wire wr_status = i_reg_wr && (i_reg_addr == AICQ_IDX_STATUS);
	// Software reset stretched to two cycles; the hardware reset acts asynchronously and is not stretched
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			swrst_cnt_q <= 2'h0;
		else if (wr_status && i_reg_wdata[AICQ_SWRST_BIT])
			swrst_cnt_q <= AICQ_SWRST_CYC;
		else if (swrst_cnt_q != 2'h0)
			swrst_cnt_q <= swrst_cnt_q - 2'h1;
	end
	assign swrst = (swrst_cnt_q != 2'h0);
	// ****************************************
	// Parallel I/O register
	// ****************************************
	logic [7:0] pio_q;
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			pio_q <= AICQ_PIO_RST;
		else if (swrst)
			pio_q <= AICQ_PIO_RST;
		else if (i_reg_wr && i_reg_addr == AICQ_IDX_PIO)
			pio_q <= i_reg_wdata[7:0];
	end
	// Bit 3 select, bit 2 powerdown, bit 1 codec reset, bit 0 unconnected
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_pio_out <= 4'h0;
			o_pio_oe <= 4'h0;
		end
		else
		begin
			o_pio_oe <= pio_q[7:4];
			o_pio_out <= pio_q[3:0];
		end
	end
	// ****************************************
	// Test register: storage only
	// ****************************************
	logic [31:0] test_q;
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			test_q <= AICQ_PTR_RST;
		else if (swrst)
			test_q <= AICQ_PTR_RST;
		else if (i_reg_wr && i_reg_addr == AICQ_IDX_TEST)
			test_q <= i_reg_wdata;
	end
	// ****************************************
	// Command fetch engine
	// ****************************************
	aicq_state_e state_q;
	logic [31:0] cmdq_q, intq_q, word1_q;
	logic run_q;
	wire cmdq_wr = i_reg_wr && (i_reg_addr == AICQ_IDX_CMDQ);
	wire [3:0] op = word1_q[AICQ_OP_HI:AICQ_OP_LO];
	// Jump and init-queue carry an address word; only jump chains via word two
	wire two_word = (op == AICQ_OP_JUMP) || (op == AICQ_OP_INITIQ);
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state_q <= AICQ_IDLE;
			cmdq_q <= AICQ_PTR_RST;
			run_q <= 1'b0;
			word1_q <= AICQ_PTR_RST;
		end
		else if (swrst)
		begin
			state_q <= AICQ_IDLE;
			cmdq_q <= AICQ_PTR_RST;
			run_q <= 1'b0;
			word1_q <= AICQ_PTR_RST;
		end
		// Pointer write beats any fetch in flight, so software can restart
		else if (cmdq_wr)
		begin
			cmdq_q <= i_reg_wdata;
			run_q <= 1'b1;
			state_q <= AICQ_FETCH1;
		end
		else
		begin
			case (state_q)
				AICQ_IDLE:
					state_q <= AICQ_IDLE;
				AICQ_FETCH1:
					if (i_mem_ack)
					begin
						word1_q <= i_mem_rdata;
						state_q <= AICQ_EXEC;
					end
				AICQ_EXEC:
					if (op == AICQ_OP_RSVD)
						state_q <= AICQ_STOP;
					else if (op == AICQ_OP_WAIT || op == AICQ_OP_PAUSE)
					begin
						// Held here until resume edge; lets earlier pipe setups settle
						if (resume_rise)
						begin
							cmdq_q <= cmdq_q + AICQ_WORD_BYTES;
							state_q <= AICQ_FETCH1;
						end
					end
					else if (two_word)
						state_q <= AICQ_FETCH2;
					else
					begin
						cmdq_q <= cmdq_q + AICQ_WORD_BYTES;
						state_q <= AICQ_FETCH1;
					end
				AICQ_FETCH2:
					if (i_mem_ack)
					begin
						if (op == AICQ_OP_JUMP)
							cmdq_q <= i_mem_rdata;
						else
							cmdq_q <= cmdq_q + AICQ_WORD_BYTES + AICQ_WORD_BYTES;
						state_q <= AICQ_FETCH1;
					end
				AICQ_STOP:
				begin
					// Reserved opcode parks the engine; only a pointer write or soft reset leaves
					run_q <= 1'b0;
					state_q <= AICQ_STOP;
				end
				default:
					state_q <= AICQ_IDLE;
			endcase
		end
	end
	// Memory request: word one at pointer, word two one word later
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_mem_req <= 1'b0;
			o_mem_addr <= AICQ_PTR_RST;
		end
		else
		begin
			// Request drops on the answer edge so one ack never takes two words
			o_mem_req <= !swrst && !cmdq_wr && !i_mem_ack
				&& (state_q == AICQ_FETCH1 || state_q == AICQ_FETCH2);
			o_mem_addr <= (state_q == AICQ_FETCH2) ? cmdq_q + AICQ_WORD_BYTES : cmdq_q;
		end
	end
	// ****************************************
	// Opcode side effects
	// ****************************************
	wire exec = (state_q == AICQ_EXEC) && !swrst && !cmdq_wr;
	wire exec1 = exec && !two_word && op != AICQ_OP_WAIT && op != AICQ_OP_PAUSE
		&& op != AICQ_OP_RSVD;
	logic [AICQ_NPIPE-1:0] pipe_q, short_q;
	logic [AICQ_NSLOT-1:0] slot_q;
	logic [15:0] slot_def_q [AICQ_NSLOT];
	logic [23:0] te_mode_q, nt_mode_q, hwy_glb_q, hwy_dat_q, codec_q, tmode_q;
	logic [1:0] pipe_sel;
	assign pipe_sel = word1_q[1:0];
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			intq_q <= AICQ_PTR_RST;
		else if (swrst)
			intq_q <= AICQ_PTR_RST;
		else if (state_q == AICQ_FETCH2 && i_mem_ack && op == AICQ_OP_INITIQ && !cmdq_wr)
			intq_q <= i_mem_rdata;
	end
	// One bit per pipe or slot; reset releases all of them
	generate
		for (genvar g = 0; g < AICQ_NPIPE; g++)
		begin : g_pipe
			always_ff @(posedge i_ref_clk or negedge i_rst_b)
			begin
				if (!i_rst_b)
				begin
					pipe_q[g] <= 1'b0;
					short_q[g] <= 1'b0;
				end
				else if (swrst)
				begin
					pipe_q[g] <= 1'b0;
					short_q[g] <= 1'b0;
				end
				else if (exec1 && pipe_sel == 2'(g))
				begin
					if (op == AICQ_OP_SETUP_PIPE || op == AICQ_OP_CONT_PIPE)
						pipe_q[g] <= 1'b1;
					if (op == AICQ_OP_SHORT_PIPE)
						short_q[g] <= 1'b1;
				end
			end
		end
		for (genvar g = 0; g < AICQ_NSLOT; g++)
		begin : g_slot
			always_ff @(posedge i_ref_clk or negedge i_rst_b)
			begin
				if (!i_rst_b)
				begin
					slot_q[g] <= 1'b0;
					slot_def_q[g] <= 16'h0000;
				end
				else if (swrst)
				begin
					slot_q[g] <= 1'b0;
					slot_def_q[g] <= 16'h0000;
				end
				else if (exec1 && op == AICQ_OP_DEF_SLOT && pipe_sel == 2'(g))
				begin
					slot_q[g] <= 1'b1;
					slot_def_q[g] <= word1_q[23:8];
				end
			end
		end
	endgenerate
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			te_mode_q <= 24'h000000;
			nt_mode_q <= 24'h000000;
			hwy_glb_q <= 24'h000000;
			hwy_dat_q <= 24'h000000;
			codec_q <= 24'h000000;
			tmode_q <= 24'h000000;
		end
		else if (swrst)
		begin
			// Soft reset returns every mode word to its power-on value
			te_mode_q <= 24'h000000;
			nt_mode_q <= 24'h000000;
			hwy_glb_q <= 24'h000000;
			hwy_dat_q <= 24'h000000;
			codec_q <= 24'h000000;
			tmode_q <= 24'h000000;
		end
		else if (exec1)
		begin
			if (op == AICQ_OP_TE_MODE)
				te_mode_q <= word1_q[23:0];
			if (op == AICQ_OP_NT_MODE)
				nt_mode_q <= word1_q[23:0];
			if (op == AICQ_OP_HWY_GLOBAL)
				hwy_glb_q <= word1_q[23:0];
			if (op == AICQ_OP_HWY_DATA)
				hwy_dat_q <= word1_q[23:0];
			if (op == AICQ_OP_CODEC)
				codec_q <= word1_q[23:0];
			if (op == AICQ_OP_TEST)
				tmode_q <= word1_q[23:0];
		end
	end
	// Completion pulse once the command leaves the execute step
	wire leave = exec && op != AICQ_OP_RSVD
		&& (!(op == AICQ_OP_WAIT || op == AICQ_OP_PAUSE) || resume_rise);
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_cmd_done <= 1'b0;
			o_cmd_done_op <= 4'h0;
		end
		else
		begin
			o_cmd_done <= leave && (word1_q[AICQ_IRQ_BIT] || op == AICQ_OP_REPORT);
			o_cmd_done_op <= leave ? op : o_cmd_done_op;
		end
	end
	// ****************************************
	// Register read port, data one cycle after strobe
	// ****************************************
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_reg_rdata <= 32'h0000_0000;
		else if (!i_reg_rd)
			o_reg_rdata <= 32'h0000_0000;
		else if (i_reg_addr == AICQ_IDX_STATUS)
			o_reg_rdata <= {16'h0000, run_q, 14'h0000, swrst};
		else if (i_reg_addr == AICQ_IDX_PIO)
			o_reg_rdata <= {20'h00000, pio_s2_q, pio_q};
		else if (i_reg_addr == AICQ_IDX_TEST)
			o_reg_rdata <= test_q;
		else if (i_reg_addr == AICQ_IDX_CMDQ)
			o_reg_rdata <= cmdq_q;
		else if (i_reg_addr == AICQ_IDX_INTQ)
			o_reg_rdata <= intq_q;
		else if (i_reg_addr == AICQ_IDX_MODE)
			o_reg_rdata <= {8'h00, te_mode_q ^ nt_mode_q ^ hwy_glb_q ^ hwy_dat_q ^ codec_q ^ tmode_q};
		// State, first slot definition and pipe flags packed into one word
		else if (i_reg_addr == AICQ_IDX_EVENT)
			o_reg_rdata <= {1'b0, state_q, slot_def_q[0], short_q, slot_q, pipe_q};
		else
			o_reg_rdata <= 32'h0000_0000;
	end
endmodule
`default_nettype wire

// ### rtl/aicq_pkg.sv
// Package for the audio/ISDN command queue front end
package aicq_pkg;
	// ****************************************
	// Register indices (byte address = 4 * index)
	// ****************************************
	localparam logic [3:0] AICQ_IDX_STATUS = 4'h0;
	localparam logic [3:0] AICQ_IDX_PIO = 4'h2;
	localparam logic [3:0] AICQ_IDX_TEST = 4'h3;
	localparam logic [3:0] AICQ_IDX_CMDQ = 4'h8;
	localparam logic [3:0] AICQ_IDX_INTQ = 4'h9;
	localparam logic [3:0] AICQ_IDX_MODE = 4'hC;
	localparam logic [3:0] AICQ_IDX_EVENT = 4'hD;
	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int AICQ_RUN_BIT = 15;
	localparam int AICQ_SWRST_BIT = 0;
	localparam int AICQ_OP_HI = 31;
	localparam int AICQ_OP_LO = 28;
	localparam int AICQ_IRQ_BIT = 27;
	localparam logic [7:0] AICQ_PIO_RST = 8'h00;
	localparam logic [31:0] AICQ_PTR_RST = 32'h0000_0000;
	// ****************************************
	// Opcodes
	// ****************************************
	localparam logic [3:0] AICQ_OP_WAIT = 4'h0;
	localparam logic [3:0] AICQ_OP_PAUSE = 4'h1;
	localparam logic [3:0] AICQ_OP_JUMP = 4'h2;
	localparam logic [3:0] AICQ_OP_INITIQ = 4'h3;
	localparam logic [3:0] AICQ_OP_REPORT = 4'h4;
	localparam logic [3:0] AICQ_OP_SETUP_PIPE = 4'h5;
	localparam logic [3:0] AICQ_OP_CONT_PIPE = 4'h6;
	localparam logic [3:0] AICQ_OP_DEF_SLOT = 4'h7;
	localparam logic [3:0] AICQ_OP_SHORT_PIPE = 4'h8;
	localparam logic [3:0] AICQ_OP_HWY_GLOBAL = 4'h9;
	localparam logic [3:0] AICQ_OP_NT_MODE = 4'hA;
	localparam logic [3:0] AICQ_OP_TE_MODE = 4'hB;
	localparam logic [3:0] AICQ_OP_CODEC = 4'hC;
	localparam logic [3:0] AICQ_OP_TEST = 4'hD;
	localparam logic [3:0] AICQ_OP_HWY_DATA = 4'hE;
	localparam logic [3:0] AICQ_OP_RSVD = 4'hF;
	// ****************************************
	// Sizes
	// ****************************************
	localparam int AICQ_NPIPE = 4;
	localparam int AICQ_NSLOT = 4;
	localparam logic [31:0] AICQ_WORD_BYTES = 32'h0000_0004;
	localparam logic [1:0] AICQ_SWRST_CYC = 2'h2;
	typedef enum logic [2:0] {
		AICQ_IDLE, AICQ_FETCH1, AICQ_EXEC, AICQ_FETCH2, AICQ_STOP
	} aicq_state_e;
endpackage

// ### tb/aicq_core_checker.sv
// Concurrent checks on the command queue core ports
`timescale 1ns/100ps
`default_nettype none
module aicq_core_checker
	import aicq_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic [3:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [31:0] o_reg_rdata,
	input wire logic o_mem_req,
	input wire logic [31:0] o_mem_addr,
	input wire logic i_mem_ack,
	input wire logic [31:0] i_mem_rdata,
	input wire logic i_resume,
	input wire logic [3:0] i_pio_in,
	input wire logic [3:0] o_pio_out,
	input wire logic [3:0] o_pio_oe,
	input wire logic o_cmd_done,
	input wire logic [3:0] o_cmd_done_op
);
	// ********
	// Helper state
	// ********
	logic started_q;
	logic word2_q;
	logic plain_w;
	// Pointer words after jump or init are not commands and must not be decoded
	assign plain_w = o_mem_req && i_mem_ack && !word2_q
		&& i_mem_rdata[31:28] inside {[AICQ_OP_REPORT:AICQ_OP_HWY_DATA]};
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			started_q <= 1'b0;
			word2_q <= 1'b0;
		end
		else
		begin
			if (i_reg_wr && i_reg_addr == AICQ_IDX_CMDQ)
				started_q <= 1'b1;
			if (o_mem_req && i_mem_ack)
				word2_q <= !word2_q && i_mem_rdata[31:29] == 3'h1;
		end
	end
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_b);
	sequence s_plain;
		plain_w;
	endsequence
	sequence s_flagged;
		plain_w && (i_mem_rdata[AICQ_IRQ_BIT] || i_mem_rdata[31:28] == AICQ_OP_REPORT);
	endsequence
	// ********
	// Assertions
	// ********
	chk_pio_write_map: assert property (i_reg_wr && i_reg_addr == AICQ_IDX_PIO |->
		##2 o_pio_oe == $past(i_reg_wdata[7:4], 2) && o_pio_out == $past(i_reg_wdata[3:0], 2))
		else $error("parallel port does not follow register write");
	chk_no_early_fetch: assert property (!started_q |-> !o_mem_req)
		else $error("fetch before pointer written");
	chk_start_fetch: assert property (i_reg_wr && i_reg_addr == AICQ_IDX_CMDQ |->
		##2 o_mem_req && o_mem_addr == $past(i_reg_wdata, 2))
		else $error("pointer write did not start fetch");
	chk_next_addr: assert property (s_plain |->
		##3 o_mem_req && o_mem_addr == $past(o_mem_addr, 3) + AICQ_WORD_BYTES)
		else $error("next command not fetched in address order");
	chk_done_op: assert property (s_flagged |->
		##2 o_cmd_done && o_cmd_done_op == $past(i_mem_rdata[31:28], 2))
		else $error("completion event missing or wrong opcode");
	chk_done_pulse: assert property (o_cmd_done |=> !o_cmd_done)
		else $error("completion event longer than one cycle");
	chk_req_hold: assert property (o_mem_req && !i_mem_ack |=>
		o_mem_req && $stable(o_mem_addr))
		else $error("fetch request dropped before answer");
	chk_req_drop: assert property (o_mem_req && i_mem_ack |=> !o_mem_req)
		else $error("fetch request held after answer");
	chk_rd_idle_zero: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
		else $error("read data outside read answer cycle");
endmodule
bind aicq_core aicq_core_checker chk_i (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
	.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
	.i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_mem_req(o_mem_req),
	.o_mem_addr(o_mem_addr), .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata),
	.i_resume(i_resume), .i_pio_in(i_pio_in), .o_pio_out(o_pio_out),
	.o_pio_oe(o_pio_oe), .o_cmd_done(o_cmd_done), .o_cmd_done_op(o_cmd_done_op));
`default_nettype wire

// ### tb/aicq_mem_model.sv
// Host memory model holding command lists
`timescale 1ns/100ps
`default_nettype none
module aicq_mem_model
(
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_slow,
	input wire logic i_mem_req,
	input wire logic [31:0] i_mem_addr,
	output logic o_mem_ack,
	output logic [31:0] o_mem_rdata
);
	logic [31:0] mem [0:127];
	logic [2:0] wait_q;
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_mem_ack <= 1'b0;
			o_mem_rdata <= 32'h0;
			wait_q <= 3'h0;
		end
		else if (i_mem_req && !o_mem_ack && (wait_q == 3'h5 || !i_slow))
		begin
			o_mem_ack <= 1'b1;
			o_mem_rdata <= mem[i_mem_addr[8:2]];
			wait_q <= 3'h0;
		end
		else
		begin
			o_mem_ack <= 1'b0;
			// Released bus shows changing garbage so stale data never passes
			o_mem_rdata <= ~o_mem_rdata;
			wait_q <= i_mem_req ? wait_q + 3'h1 : 3'h0;
		end
	end
endmodule
`default_nettype wire

// ### tb/audio_isdn_command_queue_tb_top.sv
// Self-checking testbench for the command queue core
`timescale 1ns/100ps
`default_nettype none
module audio_isdn_command_queue_tb_top
	import aicq_pkg::*;
;
	logic clk, rst_b, wr, rd, req, ack, resume, done, slow;
	logic [3:0] addr, pin, pout, poe, dop;
	logic [31:0] wdata, rdata, maddr, mdata, v;
	logic [31:0] fetched[$];
	logic [3:0] ops[$];
	int miscompares = 0;
	int total_checks = 0;
	aicq_core uut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_mem_req(req), .o_mem_addr(maddr),
		.i_mem_ack(ack), .i_mem_rdata(mdata), .i_resume(resume), .i_pio_in(pin),
		.o_pio_out(pout), .o_pio_oe(poe), .o_cmd_done(done), .o_cmd_done_op(dop));
	aicq_mem_model mem_m (.i_ref_clk(clk), .i_rst_b(rst_b), .i_slow(slow), .i_mem_req(req),
		.i_mem_addr(maddr), .o_mem_ack(ack), .o_mem_rdata(mdata));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk)
	begin
		if (req && ack)
			fetched.push_back(maddr);
		if (done)
			ops.push_back(dop);
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic wait_stop();
		int n = 0;
		rreg(AICQ_IDX_STATUS, v);
		while (v[AICQ_RUN_BIT] === 1'b1 && n < 300)
		begin
			n++;
			rreg(AICQ_IDX_STATUS, v);
		end
		check("run bit", v[AICQ_RUN_BIT], 32'h0);
	endtask
	task automatic t_pio();
		repeat (20) @(posedge clk);
		check("idle fetches", fetched.size(), 32'h0);
		check("reset oe", poe, 32'h0);
		wreg(AICQ_IDX_PIO, 32'h0000_00A5);
		@(posedge clk);
		#1;
		check("oe", poe, 32'hA);
		check("out", pout, 32'h5);
		wreg(AICQ_IDX_TEST, 32'hFFFF_FFFF);
		rreg(AICQ_IDX_PIO, v);
		check("pio read", v[11:0], 32'h6A5);
		wreg(AICQ_IDX_INTQ, 32'h0000_0123);
		rreg(AICQ_IDX_INTQ, v);
		check("intq write", v, 32'h0);
		rreg(4'h5, v);
		check("unmapped", v, 32'h0);
		$display("done pio");
	endtask
	task automatic t_list();
		for (int i = 0; i < 10; i++)
			mem_m.mem[64 + i] = {4'(i + 5), 1'b1, 27'h0};
		mem_m.mem[70] = 32'hB800_0ABC;
		mem_m.mem[74] = 32'hF000_0000;
		mem_m.mem[16] = 32'h4000_0000;
		mem_m.mem[17] = 32'h3000_0000;
		mem_m.mem[18] = 32'h0000_0180;
		mem_m.mem[19] = 32'h2000_0000;
		mem_m.mem[20] = 32'h0000_0100;
		slow <= 1'b1;
		wreg(AICQ_IDX_CMDQ, 32'h0000_0040);
		rreg(AICQ_IDX_STATUS, v);
		check("run set", v[AICQ_RUN_BIT], 32'h1);
		wait_stop();
		check("fetch count", fetched.size(), 32'd16);
		for (int k = 0; k < 16; k++)
			check("fetch addr", fetched[k], k < 5 ? 32'h40 + 4 * k : 32'hEC + 4 * k);
		check("done count", ops.size(), 32'd11);
		for (int k = 0; k < 11; k++)
			check("done op", ops[k], 32'(k + 4));
		rreg(AICQ_IDX_INTQ, v);
		check("intq", v, 32'h0000_0180);
		rreg(AICQ_IDX_CMDQ, v);
		check("cmdq", v, 32'h0000_0128);
		rreg(AICQ_IDX_MODE, v);
		check("mode word", v, 32'h0000_0ABC);
		rreg(AICQ_IDX_EVENT, v);
		check("pipe slot state", v, {1'b0, AICQ_STOP, 28'h000_0111});
		$display("done list");
	endtask
	task automatic pulse_resume();
		repeat (30) @(posedge clk);
		resume <= 1'b1;
		repeat (4) @(posedge clk);
		resume <= 1'b0;
	endtask
	task automatic t_pause();
		fetched.delete();
		ops.delete();
		slow <= 1'b0;
		mem_m.mem[112] = 32'h1000_0000;
		mem_m.mem[113] = 32'h0000_0000;
		mem_m.mem[114] = 32'h4000_0000;
		mem_m.mem[115] = 32'hF000_0000;
		wreg(AICQ_IDX_CMDQ, 32'h0000_01C0);
		pulse_resume();
		check("paused", fetched.size(), 32'd1);
		pulse_resume();
		check("waiting", fetched.size(), 32'd2);
		pulse_resume();
		wait_stop();
		check("resumed", fetched.size(), 32'd4);
		check("report op", ops[0], 32'h4);
		$display("done pause");
	endtask
	task automatic t_soft();
		wreg(AICQ_IDX_PIO, 32'h0000_00FF);
		wreg(AICQ_IDX_STATUS, 32'h0000_0001);
		repeat (4) @(posedge clk);
		rreg(AICQ_IDX_PIO, v);
		check("soft pio", v[7:0], 32'h0);
		check("soft oe", poe, 32'h0);
		rreg(AICQ_IDX_EVENT, v);
		check("soft pipes", v, 32'h0);
		$display("done soft reset");
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Whole run needs a few hundred cycles; this leaves ample margin
	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		final_report();
	end
	initial
	begin
		{rst_b, wr, rd, resume, slow} = 5'h0;
		addr = 4'h0;
		wdata = 32'h0;
		pin = 4'h6;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		t_pio();
		t_list();
		t_pause();
		t_soft();
		final_report();
	end
endmodule
`default_nettype wire
